//--- core/tone_pkg.sv
// constants and lookups for the tone, color code and polarity block
`default_nettype none
package tone_pkg;
   localparam int          CLK_HZ           = 10_000_000;
   localparam logic [7:0]  COLOR_CODE_ADDR  = 8'h01;
   localparam logic [7:0]  POLARITY_ADDR    = 8'h02;
   localparam logic [6:0]  COLOR_CODE_RESET = 7'h00;
   localparam logic [3:0]  POLARITY_RESET   = 4'h0;
   localparam int          COLOR_CODE_W     = 7;
   localparam int          POLARITY_W       = 4;
   localparam int          POL_RX_BIT       = 0;
   localparam int          POL_TX_BIT       = 1;
   localparam int          POL_RF_BIT       = 2;
   localparam int          POL_IRQ_BIT      = 3;
   // wideband and narrowband timing
   localparam int          WB_WINDOW_MS     = 100;
   localparam int          WB_WINDOW_CYC    = CLK_HZ / 1000 * WB_WINDOW_MS;
   localparam int          NB_FIRST_EVAL_MS = 120;
   localparam int          NB_EVAL_CYC      = CLK_HZ / 1000 * NB_FIRST_EVAL_MS;
   localparam int          NB_BIT_US        = 5000;
   localparam int          NB_BIT_CYC       = CLK_HZ / 1_000_000 * NB_BIT_US;
   localparam int          PERIOD_W         = 12;
   localparam int          WINDOW_W         = 21;
   // band edges and generated frequencies
   localparam int          BAND0_LO_HZ      = 5955;
   localparam int          BAND0_HI_HZ      = 5985;
   localparam int          BAND1_HI_HZ      = 6015;
   localparam int          BAND2_HI_HZ      = 6045;
   localparam int          TEST_TONE_HZ     = 6000;
   localparam int          SWING_HZ         = 15;
   localparam logic [1:0]  BAND_TEST        = 2'b11;
   localparam int          NB_WORD_W        = 24;

   typedef enum {GEN_CENTER, GEN_HIGH, GEN_LOW} gen_sel_type;

   function automatic logic [NB_WORD_W-1:0] tone_word(input logic [2:0] code);
      case (code)
         3'd0:    tone_word = 24'h2556cb;
         3'd1:    tone_word = 24'h255b2b;
         3'd2:    tone_word = 24'h256a9b;
         3'd3:    tone_word = 24'h25ad4d;
         3'd4:    tone_word = 24'h26ab2b;
         3'd5:    tone_word = 24'h26b2ad;
         3'd6:    tone_word = 24'h2969ab;
         default: tone_word = 24'h0aaaaa;
      endcase
   endfunction : tone_word

   // color code sequence left aligned in seven bits, with its length
   function automatic logic [9:0] color_seq(input logic [1:0] code);
      case (code)
         2'd0:    color_seq = {7'h00, 3'd6};
         2'd1:    color_seq = {7'h1f, 3'd7};
         2'd2:    color_seq = {7'h63, 3'd7};
         default: color_seq = {7'h78, 3'd6};
      endcase
   endfunction : color_seq
endpackage : tone_pkg
`default_nettype wire

//--- core/tone_det_if.sv
// carrier between the top and one tone detector
`default_nettype none
interface tone_det_if;
   logic       init;
   logic [2:0] code;
   logic [7:0] coef;
   logic       rx_level;
   logic       invalid;
   logic       ev;
   logic       no_tone;
   logic       off_band;
   modport ctl (output init, code, coef, rx_level, input invalid, ev, no_tone, off_band);
   modport det (input init, code, coef, rx_level, output invalid, ev, no_tone, off_band);
endinterface : tone_det_if
`default_nettype wire

//--- core/tone_wb_detect.sv
// wideband supervisory tone band detector
`default_nettype none
module tone_wb_detect #(
   parameter int WINDOW_CYC = tone_pkg::WB_WINDOW_CYC
) (
   input  wire logic   clk,
   input  wire logic   rstn,
   tone_det_if.det     d
);
   logic [tone_pkg::PERIOD_W-1:0] per_r;
   logic [tone_pkg::WINDOW_W-1:0] win_r;
   logic [7:0]                    inband_r;
   logic [7:0]                    edges_r;
   logic                          prev_r;
   logic                          first_r;
   logic [31:0]                   lo_cyc;
   logic [31:0]                   hi_cyc;
   logic                          rise;
   logic                          win_end;
   logic                          valid_nxt;

   always_comb begin
      case (d.code[1:0])
         2'd0:    begin lo_cyc = tone_pkg::CLK_HZ / tone_pkg::BAND0_HI_HZ;
                        hi_cyc = tone_pkg::CLK_HZ / tone_pkg::BAND0_LO_HZ; end
         2'd1:    begin lo_cyc = tone_pkg::CLK_HZ / tone_pkg::BAND1_HI_HZ;
                        hi_cyc = tone_pkg::CLK_HZ / tone_pkg::BAND0_HI_HZ; end
         default: begin lo_cyc = tone_pkg::CLK_HZ / tone_pkg::BAND2_HI_HZ;
                        hi_cyc = tone_pkg::CLK_HZ / tone_pkg::BAND1_HI_HZ; end
      endcase
   end
   assign rise      = d.rx_level & ~prev_r;
   assign win_end   = (32'(win_r) == 32'(WINDOW_CYC - 1));
   // test band never locks
   assign valid_nxt = (edges_r != 8'h00) && (inband_r >= d.coef) &&
                      (d.code[1:0] != tone_pkg::BAND_TEST); // R2 R7 R12

   always_ff @(posedge clk) begin
      if (!rstn) prev_r <= 1'b0;
      else       prev_r <= d.rx_level;
   end

   always_ff @(posedge clk) begin
      if (!rstn || rise)                        per_r <= '0;
      else if (per_r != {tone_pkg::PERIOD_W{1'b1}}) per_r <= per_r + 1'b1;
   end

   always_ff @(posedge clk) begin
      if (!rstn || d.init || win_end) begin
         win_r    <= '0;
         inband_r <= 8'h00;
         edges_r  <= 8'h00;
      end else begin
         win_r <= win_r + 1'b1;
         if (rise && edges_r != 8'hff) edges_r <= edges_r + 1'b1;
         if (rise && inband_r != 8'hff && 32'(per_r) >= lo_cyc && 32'(per_r) <= hi_cyc)
            inband_r <= inband_r + 1'b1; // R2
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn || d.init) begin
         d.invalid  <= 1'b1; // R4
         first_r    <= 1'b1;
         d.ev       <= 1'b0;
         d.no_tone  <= 1'b1;
         d.off_band <= 1'b0;
      end else begin
         d.ev <= win_end & (first_r | (d.invalid == valid_nxt)); // R5
         if (win_end) begin
            d.invalid  <= ~valid_nxt; // R3 R11
            first_r    <= 1'b0;
            d.no_tone  <= (edges_r == 8'h00);
            d.off_band <= (edges_r != 8'h00) & ~valid_nxt;
         end
      end
   end
endmodule : tone_wb_detect
`default_nettype wire

//--- core/tone_nb_detect.sv
// narrowband digital supervisory tone word detector
`default_nettype none
module tone_nb_detect #(
   parameter int EVAL_CYC = tone_pkg::NB_EVAL_CYC,
   parameter int BIT_CYC  = tone_pkg::NB_BIT_CYC
) (
   input  wire logic   clk,
   input  wire logic   rstn,
   tone_det_if.det     d
);
   logic [tone_pkg::NB_WORD_W-1:0] shift_r;
   logic [tone_pkg::WINDOW_W-1:0]  eval_r;
   logic [tone_pkg::WINDOW_W-1:0]  bit_r;
   logic                           hit_r;
   logic                           first_r;
   logic [7:0]                     errs;
   logic                           bit_tick;
   logic                           eval_end;

   assign bit_tick = (32'(bit_r) == 32'(BIT_CYC - 1));
   assign eval_end = (32'(eval_r) == 32'(EVAL_CYC - 1));
   assign errs     = 8'($countones(shift_r ^ tone_pkg::tone_word(d.code))); // R13
   assign d.no_tone  = 1'b0;
   assign d.off_band = 1'b0;

   always_ff @(posedge clk) begin
      if (!rstn || bit_tick) bit_r <= '0;
      else                   bit_r <= bit_r + 1'b1;
   end

   always_ff @(posedge clk) begin
      if (!rstn)         shift_r <= '0;
      else if (bit_tick) shift_r <= {shift_r[tone_pkg::NB_WORD_W-2:0], d.rx_level};
   end

   always_ff @(posedge clk) begin
      if (!rstn || d.init) begin
         eval_r    <= '0;
         hit_r     <= 1'b0;
         first_r   <= 1'b1;
         d.invalid <= 1'b1; // R15 R16
         d.ev      <= 1'b0;
      end else begin
         eval_r <= eval_end ? '0 : eval_r + 1'b1;
         d.ev   <= eval_end & (first_r | (d.invalid == hit_r)); // R17
         if (eval_end) begin
            d.invalid <= ~hit_r; // R14 R15
            hit_r     <= 1'b0;
            first_r   <= 1'b0;
         end else if (bit_tick && errs <= d.coef) begin
            hit_r <= 1'b1; // R14
         end
      end
   end
endmodule : tone_nb_detect
`default_nettype wire

//--- core/tone_color_polarity.sv
// tone color code and signal polarity control block
// What this block does
// R1: color code bits 1:0 choose the sequence inserted into control channel messages.
// R2: wideband loop locks only inside the band chosen by bits 3:2.
// R3: received tone outside selected band sets the invalid tone status flag.
// R4: wideband voice entry or color word write reinitialises detector, flag high, phase kept.
// R5: tone event set on each valid/invalid change and first evaluation.
// R6: tone event raises interrupt only when its mask bit is set.
// R7: wideband lock judged over a 0.1 s window using the lock coefficient.
// R8: wideband generator always outputs a tone inside the programmed band.
// R9: host must switch tone output off after a lost tone event.
// R10: off-band received tone makes output alternate plus and minus 15 Hz.
// R11: no received tone keeps output at band centre and flags invalid.
// R12: band code 11 outputs a fixed 6 kHz test tone, no locking.
// R13: narrowband input compared continuously against word chosen by bits 6:4.
// R14: word detected when bit errors do not exceed the error threshold.
// R15: undetected word or initialisation sets the invalid tone status flag.
// R16: narrowband entry or color word write reinitialises the narrowband detector.
// R17: narrowband event after each change and first evaluation, 0.12 s after init.
// R18: narrowband generator always sends the word for the programmed code.
// R19: signalling bit sends inverted word, switching only at word boundaries.
// R20: polarity bit 0 inverts receive data, bit 1 inverts transmit data.
// R21: polarity bit 2 makes both rf enable pins active low.
// R22: polarity bit 3 makes the interrupt pin active low.
// R23: tone transmit enable gates tone output in both modes.
// R24: unused bits of both control words have no effect.
`default_nettype none
module tone_color_polarity #(
   parameter int WB_WINDOW_CYC = tone_pkg::WB_WINDOW_CYC,
   parameter int NB_EVAL_CYC   = tone_pkg::NB_EVAL_CYC,
   parameter int NB_BIT_CYC    = tone_pkg::NB_BIT_CYC
) (
   input  wire logic       CORE_CLK,
   input  wire logic       RSTN,
   input  wire logic       REG_WR_STROBE,
   input  wire logic [7:0] REG_WR_ADDR,
   input  wire logic [7:0] REG_WR_DATA,
   input  wire logic       NARROWBAND_MODE,
   input  wire logic       VOICE_CHANNEL_MODE,
   input  wire logic       TONE_TX_ENABLE,
   input  wire logic       SIGNALLING_ENABLE,
   input  wire logic [7:0] TONE_LOCK_COEFFICIENT,
   input  wire logic [7:0] ERROR_THRESHOLD_COEFFICIENT,
   input  wire logic       TONE_EVENT_MASK,
   input  wire logic       TONE_EVENT_CLEAR,
   input  wire logic       OTHER_IRQ_REQUEST,
   input  wire logic       ARBITRATION_FAIL,
   input  wire logic       RX_RF_IDLE,
   input  wire logic       TX_DATA,
   input  wire logic       RX_DATA_INPUT,
   input  wire logic       TONE_COMPARATOR_IN,
   output logic            RX_DATA,
   output logic            TX_DATA_OUTPUT,
   output logic            TX_RF_ENABLE_PIN_O,
   output logic            TX_RF_ENABLE_PIN_OE,
   output logic            RX_RF_ENABLE_PIN_O,
   output logic            RX_RF_ENABLE_PIN_OE,
   output logic            INTERRUPT_PIN,
   output logic            TONE_OUTPUT_PIN,
   output logic            INVALID_TONE_STATUS,
   output logic            TONE_STATUS_EVENT,
   output logic [6:0]      DIGITAL_COLOR_CODE_BITS,
   output logic [2:0]      DIGITAL_COLOR_CODE_LEN
);
   logic [tone_pkg::COLOR_CODE_W-1:0] color_r;
   logic [tone_pkg::POLARITY_W-1:0]   pol_r;
   logic                              color_wr;
   logic                              pol_wr;
   logic [1:0]                        rx_sync_r;
   logic [1:0]                        cmp_sync_r;
   logic                              wb_voice;
   logic                              wb_voice_prev_r;
   logic                              nb_prev_r;
   logic                              wb_init;
   logic                              nb_init;
   logic                              event_r;
   logic                              event_set;
   logic                              irq_active;
   logic [tone_pkg::PERIOD_W-1:0]     half_cyc;
   logic [tone_pkg::PERIOD_W-1:0]     gen_cnt_r;
   logic                              wb_tone_r;
   logic                              swing_hi_r;
   tone_pkg::gen_sel_type             gen_sel;
   logic [tone_pkg::WINDOW_W-1:0]     nb_bit_r;
   logic [4:0]                        nb_idx_r;
   logic [tone_pkg::NB_WORD_W-1:0]    nb_word_r;
   logic                              nb_inv_r;
   logic                              nb_tick;
   logic                              tone_sel;
   logic [9:0]                        seq;

   tone_det_if wb_if ();
   tone_det_if nb_if ();

   // register writes from the serial port front end
   assign color_wr = REG_WR_STROBE && (REG_WR_ADDR == tone_pkg::COLOR_CODE_ADDR);
   assign pol_wr   = REG_WR_STROBE && (REG_WR_ADDR == tone_pkg::POLARITY_ADDR);

   always_ff @(posedge CORE_CLK) begin
      if (!RSTN)         color_r <= tone_pkg::COLOR_CODE_RESET;
      else if (color_wr) color_r <= REG_WR_DATA[tone_pkg::COLOR_CODE_W-1:0]; // R24
   end

   always_ff @(posedge CORE_CLK) begin
      if (!RSTN)       pol_r <= tone_pkg::POLARITY_RESET;
      else if (pol_wr) pol_r <= REG_WR_DATA[tone_pkg::POLARITY_W-1:0]; // R24
   end

   // pin synchronisers
   always_ff @(posedge CORE_CLK) begin
      if (!RSTN) begin
         rx_sync_r  <= 2'b00;
         cmp_sync_r <= 2'b00;
      end else begin
         rx_sync_r  <= {rx_sync_r[0], RX_DATA_INPUT};
         cmp_sync_r <= {cmp_sync_r[0], TONE_COMPARATOR_IN};
      end
   end

   // data polarity
   always_ff @(posedge CORE_CLK) begin
      if (!RSTN) begin
         RX_DATA        <= 1'b0;
         TX_DATA_OUTPUT <= 1'b0;
      end else begin
         RX_DATA        <= rx_sync_r[1] ^ pol_r[tone_pkg::POL_RX_BIT]; // R20
         TX_DATA_OUTPUT <= TX_DATA ^ pol_r[tone_pkg::POL_TX_BIT];      // R20
      end
   end

   // open drain rf enables: pull low when the wanted level is low
   always_ff @(posedge CORE_CLK) begin
      if (!RSTN) begin
         TX_RF_ENABLE_PIN_OE <= 1'b0;
         RX_RF_ENABLE_PIN_OE <= 1'b0;
      end else begin
         TX_RF_ENABLE_PIN_OE <= ~(ARBITRATION_FAIL ^ pol_r[tone_pkg::POL_RF_BIT]); // R21
         RX_RF_ENABLE_PIN_OE <= ~(RX_RF_IDLE ^ pol_r[tone_pkg::POL_RF_BIT]);       // R21
      end
   end
   assign TX_RF_ENABLE_PIN_O = 1'b0;
   assign RX_RF_ENABLE_PIN_O = 1'b0;

   // color code sequence
   assign seq = tone_pkg::color_seq(color_r[1:0]);
   always_ff @(posedge CORE_CLK) begin
      if (!RSTN) begin
         DIGITAL_COLOR_CODE_BITS <= 7'h00;
         DIGITAL_COLOR_CODE_LEN  <= 3'd0;
      end else begin
         DIGITAL_COLOR_CODE_BITS <= seq[9:3]; // R1
         DIGITAL_COLOR_CODE_LEN  <= seq[2:0]; // R1
      end
   end

   // detector initialisation on mode entry or color word write
   assign wb_voice = ~NARROWBAND_MODE & VOICE_CHANNEL_MODE;
   always_ff @(posedge CORE_CLK) begin
      if (!RSTN) begin
         wb_voice_prev_r <= 1'b0;
         nb_prev_r       <= 1'b0;
      end else begin
         wb_voice_prev_r <= wb_voice;
         nb_prev_r       <= NARROWBAND_MODE;
      end
   end
   assign wb_init = color_wr | (wb_voice & ~wb_voice_prev_r);        // R4
   assign nb_init = color_wr | (NARROWBAND_MODE & ~nb_prev_r);       // R16

   assign wb_if.init     = wb_init;
   assign wb_if.code     = {1'b0, color_r[3:2]};
   assign wb_if.coef     = TONE_LOCK_COEFFICIENT; // R7
   assign wb_if.rx_level = cmp_sync_r[1];
   assign nb_if.init     = nb_init;
   assign nb_if.code     = color_r[6:4];
   assign nb_if.coef     = ERROR_THRESHOLD_COEFFICIENT; // R14
   assign nb_if.rx_level = rx_sync_r[1] ^ pol_r[tone_pkg::POL_RX_BIT];

   tone_wb_detect #(
      .WINDOW_CYC (WB_WINDOW_CYC)
   ) u_wb (
      .clk  (CORE_CLK),
      .rstn (RSTN),
      .d    (wb_if.det)
   );

   tone_nb_detect #(
      .EVAL_CYC (NB_EVAL_CYC),
      .BIT_CYC  (NB_BIT_CYC)
   ) u_nb (
      .clk  (CORE_CLK),
      .rstn (RSTN),
      .d    (nb_if.det)
   );

   // status, event and interrupt
   always_ff @(posedge CORE_CLK) begin
      if (!RSTN) INVALID_TONE_STATUS <= 1'b1;
      else       INVALID_TONE_STATUS <= NARROWBAND_MODE ? nb_if.invalid : wb_if.invalid; // R3 R15
   end

   assign event_set = NARROWBAND_MODE ? nb_if.ev : (wb_voice & wb_if.ev); // R5 R17

   // set wins over clear
   always_ff @(posedge CORE_CLK) begin
      if (!RSTN)                 event_r <= 1'b0;
      else if (event_set)        event_r <= 1'b1;
      else if (TONE_EVENT_CLEAR) event_r <= 1'b0;
   end
   assign TONE_STATUS_EVENT = event_r;

   assign irq_active = (event_r & TONE_EVENT_MASK) | OTHER_IRQ_REQUEST; // R6
   always_ff @(posedge CORE_CLK) begin
      if (!RSTN) INTERRUPT_PIN <= pol_r[tone_pkg::POL_IRQ_BIT] ;
      else       INTERRUPT_PIN <= irq_active ^ pol_r[tone_pkg::POL_IRQ_BIT]; // R22
   end

   // wideband tone generator, never reset by detector init
   always_comb begin
      if (color_r[3:2] == tone_pkg::BAND_TEST)
         gen_sel = tone_pkg::GEN_CENTER; // R12
      else if (wb_if.off_band)
         gen_sel = swing_hi_r ? tone_pkg::GEN_HIGH : tone_pkg::GEN_LOW; // R10
      else
         gen_sel = tone_pkg::GEN_CENTER; // R8 R11
   end

   always_comb begin
      logic [31:0] hz;
      hz = 32'(tone_pkg::TEST_TONE_HZ);
      case (color_r[3:2])
         2'd0:    hz = 32'((tone_pkg::BAND0_LO_HZ + tone_pkg::BAND0_HI_HZ) / 2);
         2'd1:    hz = 32'((tone_pkg::BAND0_HI_HZ + tone_pkg::BAND1_HI_HZ) / 2);
         2'd2:    hz = 32'((tone_pkg::BAND1_HI_HZ + tone_pkg::BAND2_HI_HZ) / 2);
         default: hz = 32'(tone_pkg::TEST_TONE_HZ); // R12
      endcase
      case (gen_sel)
         tone_pkg::GEN_HIGH: hz = hz + 32'(tone_pkg::SWING_HZ);
         tone_pkg::GEN_LOW:  hz = hz - 32'(tone_pkg::SWING_HZ);
         default:            hz = hz;
      endcase
      half_cyc = tone_pkg::PERIOD_W'(32'(tone_pkg::CLK_HZ / 2) / hz);
   end

   always_ff @(posedge CORE_CLK) begin
      if (!RSTN) begin
         gen_cnt_r  <= '0;
         wb_tone_r  <= 1'b0;
         swing_hi_r <= 1'b0;
      end else if (gen_cnt_r + 1'b1 >= half_cyc) begin
         gen_cnt_r <= '0;
         wb_tone_r <= ~wb_tone_r; // R4 R8
         if (wb_tone_r) swing_hi_r <= ~swing_hi_r; // R10
      end else begin
         gen_cnt_r <= gen_cnt_r + 1'b1;
      end
   end

   // narrowband word generator, inversion changes only at word start
   assign nb_tick = (32'(nb_bit_r) == 32'(NB_BIT_CYC - 1));
   always_ff @(posedge CORE_CLK) begin
      if (!RSTN || nb_tick) nb_bit_r <= '0;
      else                  nb_bit_r <= nb_bit_r + 1'b1;
   end

   always_ff @(posedge CORE_CLK) begin
      if (!RSTN) begin
         nb_idx_r  <= 5'd0;
         nb_word_r <= tone_pkg::tone_word(3'd0);
         nb_inv_r  <= 1'b0;
      end else if (nb_tick) begin
         if (nb_idx_r == 5'(tone_pkg::NB_WORD_W - 1)) begin
            nb_idx_r  <= 5'd0;
            nb_word_r <= tone_pkg::tone_word(color_r[6:4]); // R18
            nb_inv_r  <= SIGNALLING_ENABLE;                  // R19
         end else begin
            nb_idx_r <= nb_idx_r + 5'd1;
         end
      end
   end

   assign tone_sel = NARROWBAND_MODE ?
                     (nb_word_r[5'(tone_pkg::NB_WORD_W - 1) - nb_idx_r] ^ nb_inv_r) : // R19
                     wb_tone_r;

   always_ff @(posedge CORE_CLK) begin
      if (!RSTN) TONE_OUTPUT_PIN <= 1'b0;
      else       TONE_OUTPUT_PIN <= TONE_TX_ENABLE & tone_sel; // R23 R9
   end
endmodule : tone_color_polarity
`default_nettype wire

//--- dv/tone_cp_monitor.sv
// port level checks for the tone color code and polarity block
`default_nettype none
module tone_cp_monitor (
   input wire logic       CORE_CLK,
   input wire logic       RSTN,
   input wire logic       REG_WR_STROBE,
   input wire logic [7:0] REG_WR_ADDR,
   input wire logic [7:0] REG_WR_DATA,
   input wire logic       TONE_TX_ENABLE,
   input wire logic       TONE_EVENT_MASK,
   input wire logic       TONE_EVENT_CLEAR,
   input wire logic       OTHER_IRQ_REQUEST,
   input wire logic       ARBITRATION_FAIL,
   input wire logic       RX_RF_IDLE,
   input wire logic       TX_DATA,
   input wire logic       TX_DATA_OUTPUT,
   input wire logic       TX_RF_ENABLE_PIN_OE,
   input wire logic       RX_RF_ENABLE_PIN_O,
   input wire logic       RX_RF_ENABLE_PIN_OE,
   input wire logic       INTERRUPT_PIN,
   input wire logic       TONE_OUTPUT_PIN,
   input wire logic       INVALID_TONE_STATUS,
   input wire logic       TONE_STATUS_EVENT,
   input wire logic [6:0] DIGITAL_COLOR_CODE_BITS
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] pol_r;
   logic [1:0] dcc_r;
   logic [6:0] seq;
   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (!RSTN);
   // shadow copies of the write-only words
   always_ff @(posedge CORE_CLK) begin
      if (!RSTN) begin
         pol_r <= 4'h0;
         dcc_r <= 2'h0;
      end else if (REG_WR_STROBE && REG_WR_ADDR == 8'h02) begin
         pol_r <= REG_WR_DATA[3:0];
      end else if (REG_WR_STROBE && REG_WR_ADDR == 8'h01) begin
         dcc_r <= REG_WR_DATA[1:0];
      end
   end
   always_comb begin
      case (dcc_r)
         2'd0:    seq = 7'h00;
         2'd1:    seq = 7'h1f;
         2'd2:    seq = 7'h63;
         default: seq = 7'h78;
      endcase
   end
   sequence s_color_wr;
      REG_WR_STROBE && REG_WR_ADDR == 8'h01;
   endsequence
   sequence s_flag_up;
      ##[2:3] INVALID_TONE_STATUS;
   endsequence
   a_color_seq: assert property ($past(RSTN) |-> DIGITAL_COLOR_CODE_BITS == $past(seq))
      else $error("color code sequence wrong");
   a_tx_sense: assert property ($past(RSTN) |->
      TX_DATA_OUTPUT == ($past(TX_DATA) ^ $past(pol_r[1])))
      else $error("transmit data sense wrong");
   a_txrf_sense: assert property ($past(RSTN) |->
      TX_RF_ENABLE_PIN_OE == !($past(ARBITRATION_FAIL) ^ $past(pol_r[2])))
      else $error("tx rf enable sense wrong");
   a_rxrf_sense: assert property ($past(RSTN) |-> !RX_RF_ENABLE_PIN_O &&
      RX_RF_ENABLE_PIN_OE == !($past(RX_RF_IDLE) ^ $past(pol_r[2])))
      else $error("rx rf enable sense wrong");
   a_irq_sense: assert property ($past(RSTN) |-> INTERRUPT_PIN == ($past(pol_r[3]) ^
      $past((TONE_STATUS_EVENT && TONE_EVENT_MASK) || OTHER_IRQ_REQUEST)))
      else $error("interrupt pin wrong");
   a_init_invalid: assert property (s_color_wr |-> s_flag_up)
      else $error("invalid flag not raised on write");
   a_event_hold: assert property (TONE_STATUS_EVENT && !TONE_EVENT_CLEAR |=>
      TONE_STATUS_EVENT)
      else $error("tone event dropped");
   a_tone_gate: assert property ($past(RSTN) && !$past(TONE_TX_ENABLE) |->
      !TONE_OUTPUT_PIN)
      else $error("tone output not gated");
endmodule : tone_cp_monitor
bind tone_color_polarity tone_cp_monitor i_mon (.CORE_CLK, .RSTN, .REG_WR_STROBE,
   .REG_WR_ADDR, .REG_WR_DATA, .TONE_TX_ENABLE, .TONE_EVENT_MASK, .TONE_EVENT_CLEAR,
   .OTHER_IRQ_REQUEST, .ARBITRATION_FAIL, .RX_RF_IDLE, .TX_DATA, .TX_DATA_OUTPUT,
   .TX_RF_ENABLE_PIN_OE, .RX_RF_ENABLE_PIN_O, .RX_RF_ENABLE_PIN_OE, .INTERRUPT_PIN,
   .TONE_OUTPUT_PIN, .INVALID_TONE_STATUS, .TONE_STATUS_EVENT, .DIGITAL_COLOR_CODE_BITS);
`default_nettype wire

//--- dv/tone_src.sv
// received tone comparator source: square wave or silent
`default_nettype none
module tone_src (
   input  wire logic        clk,
   input  wire logic        on,
   input  wire logic [11:0] half,
   output logic             tone
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [11:0] cnt_r;
   always_ff @(posedge clk) begin
      if (!on) begin
         cnt_r <= 12'h0;
         tone <= 1'b0;
      end else if (cnt_r == half - 12'h1) begin
         cnt_r <= 12'h0;
         tone <= !tone;
      end else begin
         cnt_r <= cnt_r + 12'h1;
      end
   end
endmodule : tone_src
`default_nettype wire

//--- dv/tb_top.sv
// register sequence tests of the tone color code and polarity block
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk;
   logic rstn = 0, stb = 0, msk = 0, clr = 0, oirq = 0, arb = 0, idl = 0, txd = 0;
   logic rxd = 0, txen = 0, vm = 0, on = 0, nb = 0, sig = 0, prev;
   logic [7:0] addr = 8'h00, data = 8'h00;
   logic [11:0] half = 12'd833;
   logic tone, rx_o, tx_o, trf_o, trf_oe, rrf_o, rrf_oe, irq, tpin, inv, ev;
   logic [6:0] bits;
   logic [2:0] len;
   logic [6:0] seq_t [4] = '{7'h00, 7'h1f, 7'h63, 7'h78};
   logic [2:0] len_t [4] = '{3'd6, 3'd7, 3'd7, 3'd6};
   int err_count = 0, comparisons = 0, n;
   tone_color_polarity #(.WB_WINDOW_CYC(20000), .NB_EVAL_CYC(5000), .NB_BIT_CYC(20)) i_dut (
      .CORE_CLK(clk), .RSTN(rstn), .REG_WR_STROBE(stb), .REG_WR_ADDR(addr),
      .REG_WR_DATA(data), .NARROWBAND_MODE(nb), .VOICE_CHANNEL_MODE(vm),
      .TONE_TX_ENABLE(txen), .SIGNALLING_ENABLE(sig), .TONE_LOCK_COEFFICIENT(8'd5),
      .ERROR_THRESHOLD_COEFFICIENT(8'd2), .TONE_EVENT_MASK(msk), .TONE_EVENT_CLEAR(clr),
      .OTHER_IRQ_REQUEST(oirq), .ARBITRATION_FAIL(arb), .RX_RF_IDLE(idl), .TX_DATA(txd),
      .RX_DATA_INPUT(rxd), .TONE_COMPARATOR_IN(tone), .RX_DATA(rx_o), .TX_DATA_OUTPUT(tx_o),
      .TX_RF_ENABLE_PIN_O(trf_o), .TX_RF_ENABLE_PIN_OE(trf_oe), .RX_RF_ENABLE_PIN_O(rrf_o),
      .RX_RF_ENABLE_PIN_OE(rrf_oe), .INTERRUPT_PIN(irq), .TONE_OUTPUT_PIN(tpin),
      .INVALID_TONE_STATUS(inv), .TONE_STATUS_EVENT(ev), .DIGITAL_COLOR_CODE_BITS(bits),
      .DIGITAL_COLOR_CODE_LEN(len));
   tone_src i_src (.clk(clk), .on(on), .half(half), .tone(tone));
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      stb <= 1'b1;
      addr <= a;
      data <= d;
      @(posedge clk);
      stb <= 1'b0;
   endtask : wr
   task automatic cyc(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask : cyc
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      comparisons++;
      if (g !== e) begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic give_verdict;
      if (err_count == 0 && comparisons > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : give_verdict
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   initial begin
      repeat (90000) @(posedge clk);
      err_count++;
      give_verdict();
   end
   initial begin
      repeat (20) @(posedge clk);
      rstn <= 1'b1;
      for (int c = 0; c < 4; c++) begin
         wr(8'h01, 8'h84 + 8'(c));
         cyc(3);
         chk("dcc_bits", 8'(seq_t[c]), 8'(bits));
         chk("dcc_len", 8'(len_t[c]), 8'(len));
         chk("invalid_init", 8'h01, 8'(inv));
      end
      oirq <= 1'b1;
      for (int p = 0; p < 16; p++) begin
         wr(8'h02, 8'hf0 + 8'(p));
         arb <= !p[0];
         idl <= p[1];
         txd <= p[2];
         rxd <= p[3];
         cyc(5);
         chk("data_pins", {6'h0, p[2] ^ p[1], p[3] ^ p[0]}, {6'h0, tx_o, rx_o});
         chk("rf_irq_pins", {4'h0, p[0] ^ p[2], 1'b0, p[1] ~^ p[2], !p[3]},
             {4'h0, trf_oe, trf_o, rrf_oe, irq});
      end
      wr(8'h02, 8'h00);
      oirq <= 1'b0;
      vm <= 1'b1;
      txen <= 1'b1;
      on <= 1'b1;
      wr(8'h01, 8'h04);
      for (int i = 0; i < 60000 && inv !== 1'b0; i++) @(posedge clk);
      cyc(2);
      chk("lock_valid", 8'h00, 8'(inv));
      chk("event_set", 8'h01, 8'(ev));
      chk("irq_masked", 8'h00, 8'(irq));
      msk <= 1'b1;
      cyc(2);
      chk("irq_unmasked", 8'h01, 8'(irq));
      clr <= 1'b1;
      cyc(1);
      clr <= 1'b0;
      cyc(2);
      chk("event_clear", 8'h00, 8'(ev));
      wr(8'h01, 8'h00);
      cyc(22000);
      chk("off_band", 8'h01, 8'(inv));
      chk("first_eval", 8'h01, 8'(ev));
      on <= 1'b0;
      wr(8'h01, 8'h0c);
      n = 0;
      prev = tpin;
      repeat (20000) begin
         cyc(1);
         if (tpin && !prev) n++;
         prev = tpin;
      end
      chk("test_tone", 8'h01, 8'(n >= 11 && n <= 13));
      chk("test_invalid", 8'h01, 8'(inv));
      txen <= 1'b0;
      cyc(5);
      chk("tone_off", 8'h00, 8'(tpin));
      clr <= 1'b1;
      nb <= 1'b1;
      cyc(1);
      clr <= 1'b0;
      cyc(5100);
      chk("nb_first_eval", 8'h01, 8'(ev));
      chk("nb_invalid", 8'h01, 8'(inv));
      sig <= 1'b1;
      txen <= 1'b1;
      wr(8'h01, 8'h70);
      cyc(500);
      n = 0;
      repeat (480) begin
         cyc(1);
         n += tpin;
      end
      chk("dst_ones", 8'h0e, 8'(n / 20));
      give_verdict();
   end
endmodule : tb_top
`default_nettype wire
